// *** verilog/sadc_pkg.sv ***
// Package of constants and types for the converter control block
package sadc_pkg;

  // Register offsets on the plain register port (8-bit address)
  localparam logic [7:0] OFF_PRIMARY_CONTROL = 8'h1f;
  localparam logic [7:0] OFF_RESULT          = 8'h1e;
  localparam logic [7:0] OFF_PORT_CONFIG     = 8'h9f;
  localparam logic [7:0] OFF_IRQ_STATUS      = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK        = 8'h21;

  // Primary control field positions
  localparam int CLKSEL_HI = 7;
  localparam int CLKSEL_LO = 6;
  localparam int CHAN_HI   = 5;
  localparam int CHAN_LO   = 3;
  localparam int GO_BIT    = 2;
  localparam int PWR_BIT   = 0;

  // Port configuration field positions
  localparam int PCFG_HI   = 2;
  localparam int PCFG_LO   = 0;
  localparam int VREF_BIT  = 3;

  // Reset values
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [7:0] PORTCFG_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [0:0] IRQ_RESET     = 1'h0;

  // Writable bits of the primary control register (bit 1 unimplemented)
  localparam logic [7:0] PRIMARY_WMASK = 8'hfd;

  // Conversion clock dividers, in system clocks per conversion bit period
  localparam logic [5:0] DIV_2  = 6'h02;
  localparam logic [5:0] DIV_8  = 6'h08;
  localparam logic [5:0] DIV_32 = 6'h20;
  // Internal RC bit period stand-in, in system clocks
  localparam logic [5:0] DIV_RC = 6'h10;

  // Highest legal channel code
  localparam logic [2:0] CHAN_MAX = 3'h4;
  localparam int         NUM_CHAN = 5;
  localparam int         RES_W    = 8;

  // Conversion clock select codes
  typedef enum logic [1:0] {
    SADC_CLK_DIV2 = 2'b00,
    SADC_CLK_DIV8 = 2'b01,
    SADC_CLK_DIV32 = 2'b10,
    SADC_CLK_RC   = 2'b11
  } sadc_clksel_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10
  } sadc_state_t;

endpackage

// *** verilog/sadc_ctrl.sv ***
// Successive-approximation converter control with register port and interrupt
//
// Behaviour
// - five channels chosen by 3-bit field
// - 8-bit result by successive approximation
// - reference is supply or reference pin
// - conversion continues in sleep only with RC
// - result, control and port-config registers
// - reset restores registers, converter off
// - reset aborts a running conversion
// - clock field picks div 2/8/32 or RC
// - writing start flag begins conversion
// - hardware clears start flag when done
// - port config selects analog, digital, reference
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

module sadc_ctrl (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_b,
  // Register port
  input  wire logic [7:0]                    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [7:0]                    o_rdata,
  // Device sleep and internal RC tick
  input  wire logic                          i_sleep,
  input  wire logic                          i_rc_tick,
  // Analog front end
  input  wire logic                          i_cmp,
  output logic      [sadc_pkg::RES_W-1:0]    o_dac,
  output logic                               o_sample,
  output logic      [sadc_pkg::NUM_CHAN-1:0] o_chan_sel,
  output logic                               o_ref_ext,
  output logic      [sadc_pkg::NUM_CHAN-1:0] o_pin_analog,
  output logic                               o_powered,
  // Interrupt
  output logic                               o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Block state

  typedef struct packed {
    // Software registers
    logic [7:0]            ctrl;
    logic [7:0]            pcfg;
    logic [7:0]            res;
    // Done event status and its mask
    logic                  ist;
    logic                  imask;
    // Conversion sequencer
    sadc_pkg::sadc_state_t st;
    logic [5:0]            div;
    logic [2:0]            bitn;
    logic [7:0]            sar;
    // Registered read data
    logic [7:0]            rdata;
  } sadc_state_s_t;

  sadc_state_s_t s_q;
  sadc_state_s_t s_d;

  // Conversion clock
  logic [5:0] div_top;
  logic       clk_rc;
  logic       tick;
  logic       run_ok;
  logic       step;
  logic       last_bit;
  logic       done;

  // Sequencer phase
  logic       in_idle;
  logic       in_sample;
  logic       in_conv;

  // Register port decode
  logic       wr_ctrl;
  logic       wr_pcfg;
  logic       wr_mask;
  logic       wr_stat;
  logic       stat_clr;
  logic       rd_ctrl;
  logic       rd_res;
  logic       rd_pcfg;
  logic       rd_stat;
  logic       rd_mask;
  logic [7:0] rd_word;

  // Control fields
  logic       power_on;
  logic       start_req;
  logic [2:0] chan_code;
  logic [2:0] analog_cnt;
  logic [7:0] ctrl_wr;

  // Successive-approximation step
  logic [7:0] trial_mask;
  logic [7:0] next_mask;
  logic [7:0] sar_next;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock selection

  assign clk_rc = (s_q.ctrl[sadc_pkg::CLKSEL_HI:sadc_pkg::CLKSEL_LO] == 2'b11);

  always_comb begin
    case (sadc_pkg::sadc_clksel_t'(s_q.ctrl[sadc_pkg::CLKSEL_HI:sadc_pkg::CLKSEL_LO]))
      sadc_pkg::SADC_CLK_DIV2: begin
        div_top = sadc_pkg::DIV_2;
      end
      sadc_pkg::SADC_CLK_DIV8: begin
        div_top = sadc_pkg::DIV_8;
      end
      sadc_pkg::SADC_CLK_DIV32: begin
        div_top = sadc_pkg::DIV_32;
      end
      default: begin
        div_top = sadc_pkg::DIV_RC;
      end
    endcase
  end

  // Conversion tick: RC source uses its own tick input
  assign tick = clk_rc ? i_rc_tick : (s_q.div == div_top - 6'h01);
  // System-clock conversions stall in sleep; RC ones keep going
  assign run_ok   = !i_sleep || clk_rc;
  assign step     = tick && run_ok;
  assign last_bit = (s_q.bitn == 3'h0);
  assign done     = in_conv && step && last_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer phase

  assign in_idle   = (s_q.st == sadc_pkg::SADC_IDLE);
  assign in_sample = (s_q.st == sadc_pkg::SADC_SAMPLE);
  assign in_conv   = (s_q.st == sadc_pkg::SADC_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode

  assign wr_ctrl  = i_wr && (i_addr == sadc_pkg::OFF_PRIMARY_CONTROL);
  assign wr_pcfg  = i_wr && (i_addr == sadc_pkg::OFF_PORT_CONFIG);
  assign wr_mask  = i_wr && (i_addr == sadc_pkg::OFF_IRQ_MASK);
  assign wr_stat  = i_wr && (i_addr == sadc_pkg::OFF_IRQ_STATUS);
  // Status clears by writing a one
  assign stat_clr = wr_stat && i_wdata[0];

  // Read strobes
  assign rd_ctrl  = i_rd && (i_addr == sadc_pkg::OFF_PRIMARY_CONTROL);
  assign rd_res   = i_rd && (i_addr == sadc_pkg::OFF_RESULT);
  assign rd_pcfg  = i_rd && (i_addr == sadc_pkg::OFF_PORT_CONFIG);
  assign rd_stat  = i_rd && (i_addr == sadc_pkg::OFF_IRQ_STATUS);
  assign rd_mask  = i_rd && (i_addr == sadc_pkg::OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  assign power_on   = s_q.ctrl[sadc_pkg::PWR_BIT];
  assign start_req  = s_q.ctrl[sadc_pkg::GO_BIT] && power_on;
  // Channel code and count of analog pins
  assign chan_code  = s_q.ctrl[sadc_pkg::CHAN_HI:sadc_pkg::CHAN_LO];
  assign analog_cnt = s_q.pcfg[sadc_pkg::PCFG_HI:sadc_pkg::PCFG_LO];
  // Unimplemented bit 1 never stores a one
  assign ctrl_wr    = i_wdata & sadc_pkg::PRIMARY_WMASK;

  ////////////////////////////////////////////////////////////////////////////
  // Successive-approximation step

  // Bit under test now, and the next lower bit to try
  assign trial_mask = 8'h01 << s_q.bitn;
  assign next_mask  = {1'b0, trial_mask[7:1]};

  // Keep the trial bit only if the held level is at or above it
  always_comb begin
    sar_next = s_q.sar;
    if (!i_cmp) begin
      sar_next = sar_next & ~trial_mask;
    end
    if (!last_bit) begin
      sar_next = sar_next | next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux

  // Zero outside a read slot and for unmapped addresses
  always_comb begin
    rd_word = 8'h00;
    if (rd_ctrl) begin
      rd_word = s_q.ctrl & sadc_pkg::PRIMARY_WMASK;
    end
    if (rd_res) begin
      rd_word = s_q.res;
    end
    if (rd_pcfg) begin
      rd_word = s_q.pcfg;
    end
    if (rd_stat) begin
      rd_word = {7'h00, s_q.ist};
    end
    if (rd_mask) begin
      rd_word = {7'h00, s_q.imask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // Divider runs only while a conversion is under way
    if (run_ok && !in_idle) begin
      s_d.div = tick ? 6'h00 : s_q.div + 6'h01;
    end
    case (s_q.st)
      // Wait for a start with the converter powered
      sadc_pkg::SADC_IDLE: begin
        s_d.div = 6'h00;
        if (start_req) begin
          s_d.st   = sadc_pkg::SADC_SAMPLE;
          s_d.bitn = 3'h7;
          s_d.sar  = 8'h80;
        end
      end
      // Hold the input for one conversion tick
      sadc_pkg::SADC_SAMPLE: begin
        if (tick && run_ok) begin
          s_d.st = sadc_pkg::SADC_CONV;
        end
      end
      // One bit per tick, most significant first
      sadc_pkg::SADC_CONV: begin
        if (step) begin
          s_d.sar = sar_next;
          if (!last_bit) begin
            s_d.bitn = s_q.bitn - 3'h1;
          end else begin
            s_d.res = sar_next;
            s_d.ctrl[sadc_pkg::GO_BIT] = 1'b0;
            s_d.st = sadc_pkg::SADC_IDLE;
          end
        end
      end
      default: s_d.st = sadc_pkg::SADC_IDLE;
    endcase
    // Power-down stops any conversion in flight
    if (!s_q.ctrl[sadc_pkg::PWR_BIT]) begin
      s_d.st = sadc_pkg::SADC_IDLE;
      s_d.ctrl[sadc_pkg::GO_BIT] = 1'b0;
    end

    // Control register write
    if (wr_ctrl) begin
      s_d.ctrl = ctrl_wr;
      // A start is refused while powered down, and ignored mid-conversion
      if (!ctrl_wr[sadc_pkg::PWR_BIT]) begin
        s_d.ctrl[sadc_pkg::GO_BIT] = 1'b0;
        s_d.st = sadc_pkg::SADC_IDLE;
      end else if (!in_idle) begin
        s_d.ctrl[sadc_pkg::GO_BIT] = !done;
        s_d.ctrl[sadc_pkg::CLKSEL_HI:sadc_pkg::CHAN_LO] =
          s_q.ctrl[sadc_pkg::CLKSEL_HI:sadc_pkg::CHAN_LO];
      end
    end

    // Port configuration and interrupt mask
    if (wr_pcfg) begin
      s_d.pcfg = {4'h0, i_wdata[3:0]};
    end
    if (wr_mask) begin
      s_d.imask = i_wdata[0];
    end

    // Sticky done event; set wins over write-one-to-clear
    if (stat_clr) begin
      s_d.ist = 1'b0;
    end
    if (done) begin
      s_d.ist = 1'b1;
    end

    // Read data stands for the one cycle after the strobe
    s_d.rdata = rd_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset turns the converter off and drops any conversion
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s_q.ctrl  <= sadc_pkg::PRIMARY_RESET;
      s_q.pcfg  <= sadc_pkg::PORTCFG_RESET;
      s_q.res   <= sadc_pkg::RESULT_RESET;
      s_q.ist   <= sadc_pkg::IRQ_RESET;
      s_q.imask <= sadc_pkg::IRQ_RESET;
      s_q.st    <= sadc_pkg::SADC_IDLE;
      s_q.div   <= 6'h00;
      s_q.bitn  <= 3'h0;
      s_q.sar   <= 8'h00;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read port
  assign o_rdata   = s_q.rdata;

  // Trial value to the comparator's DAC
  assign o_dac     = s_q.sar;

  // Sample phase drives the hold switch
  assign o_sample  = in_sample;

  // Power and reference selection
  assign o_powered = power_on;
  assign o_ref_ext = s_q.pcfg[sadc_pkg::VREF_BIT];

  // Level interrupt from the sticky status bit
  assign o_irq     = s_q.ist & s_q.imask;

  // Analog multiplexer and pin modes
  genvar g;
  generate
    for (g = 0; g < sadc_pkg::NUM_CHAN; g++) begin : g_chan
      // Channel code g selects input g; codes above 4 select none
      assign o_chan_sel[g] = power_on && (chan_code == 3'(g));
      // Pins below the configured count are analog; input 3 digital if used as reference
      assign o_pin_analog[g] = (3'(g) < analog_cnt)
                             && !(g == 3 && s_q.pcfg[sadc_pkg::VREF_BIT]);
    end
  endgenerate

endmodule // sadc_ctrl

// *** verif/sadc_front_model.sv ***
// Behavioural analog front end: held channel level and comparator
`timescale 1ns/100ps
module sadc_front_model #(
  parameter logic [39:0] LEVELS = 40'h00_0000_0000
) (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dac,
  input  wire logic [4:0] i_chan_sel,
  input  wire logic       i_sample,
  output logic            o_cmp
);
  logic [7:0] held_q = 8'h00;
  always @(posedge i_clk) begin
    for (int c = 0; c < 5; c++) begin
      if (i_sample && i_chan_sel[c]) held_q <= LEVELS[c*8 +: 8];
    end
  end
  assign o_cmp = (held_q >= i_dac);
endmodule // sadc_front_model

// *** verif/sadc_ctrl_props.sv ***
// Port checker for the converter control block
`timescale 1ns/100ps
module sadc_ctrl_props (
  input wire logic       i_clk, i_rst_b, i_wr, i_rd,
  input wire logic [7:0] i_addr, i_wdata, o_rdata, o_dac,
  input wire logic [4:0] o_chan_sel,
  input wire logic       o_sample, o_ref_ext, o_powered, o_irq
);
  logic [7:0] wd_q;
  always_ff @(posedge i_clk) wd_q <= i_wdata;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_pwr_write: assert property (i_wr && i_addr == sadc_pkg::OFF_PRIMARY_CONTROL
    |=> o_powered == wd_q[0] && (wd_q[0] || !o_sample)) else $error("power bit not applied");
  a_ref_write: assert property (i_wr && i_addr == sadc_pkg::OFF_PORT_CONFIG
    |=> o_ref_ext == wd_q[3]) else $error("reference select not applied");
  a_bit1_zero: assert property (i_rd && i_addr == sadc_pkg::OFF_PRIMARY_CONTROL
    |=> !o_rdata[1]) else $error("unused bit reads one");
  a_chan_onehot: assert property ($onehot0(o_chan_sel)) else $error("channel select");
  a_power_gate: assert property (!o_powered |-> o_chan_sel == 5'h00 && !o_sample)
    else $error("front end active while off");
  a_reset_off: assert property ($rose(i_rst_b) |-> !o_powered && !o_irq && o_dac == 8'h00)
    else $error("outputs not reset");
  a_dac_start: assert property ($fell(o_sample) && o_powered |-> o_dac == 8'h80)
    else $error("first trial value wrong");
  cover property ($fell(o_sample));
  cover property (o_irq);
  cover property (i_rd && i_addr == sadc_pkg::OFF_RESULT);
endmodule // sadc_ctrl_props
bind sadc_ctrl sadc_ctrl_props chk_u (.i_clk, .i_rst_b, .i_wr, .i_rd, .i_addr, .i_wdata,
  .o_rdata, .o_dac, .o_chan_sel, .o_sample, .o_ref_ext, .o_powered, .o_irq);

// *** verif/tb_sadc_ctrl.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_sadc_ctrl;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sadc_row_t;
  localparam logic [39:0] LVL = 40'h80_01ff_a53c;
  logic       i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic       i_sleep = 1'b0, i_rc_tick = 1'b0, i_cmp;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_dac, rd_v;
  logic [4:0] o_chan_sel, o_pin_analog;
  logic       o_sample, o_ref_ext, o_powered, o_irq;
  logic [1:0] tick_cnt = 2'h0;
  int         mismatches = 0, samples_checked = 0, n, dv;
  sadc_row_t  rows[6] = '{'{8'h1f, 8'hfe, 8'hf8}, '{8'h9f, 8'h0b, 8'h0b},
    '{8'h21, 8'h01, 8'h01}, '{8'h1e, 8'h5a, 8'h00}, '{8'h55, 8'hff, 8'h00},
    '{8'h1f, 8'h00, 8'h00}};
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    tick_cnt  <= tick_cnt + 2'h1;
    i_rc_tick <= (tick_cnt == 2'h3);
  end
  sadc_ctrl dut_u (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep,
    .i_rc_tick, .i_cmp, .o_dac, .o_sample, .o_chan_sel, .o_ref_ext, .o_pin_analog,
    .o_powered, .o_irq);
  sadc_front_model #(.LEVELS(LVL)) fe_u (.i_clk, .i_dac(o_dac), .i_chan_sel(o_chan_sel),
    .i_sample(o_sample), .o_cmp(i_cmp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic finish_test;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rd_v);
      chk(rd_v, rows[k].e);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h1f, 8'((c << 3) | 1));
      chk(8'(o_chan_sel), c < 5 ? 8'(1 << c) : 8'h00);
    end
    for (int p = 0; p < 6; p++) begin
      wr(8'h9f, 8'(p | (p[0] << 3)));
      chk({2'b00, o_ref_ext, o_pin_analog},
          8'((p[0] << 5) | (((1 << p) - 1) & ~((p > 3 && p[0]) ? 8 : 0))));
    end
    wr(8'h21, 8'h01);
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clk) i_sleep <= (m == 3);
      wr(8'h1f, 8'((m << 6) | (m << 3) | 5));
      dv = (m == 3) ? 4 : (2 << (2 * m));
      n = 0;
      while (o_irq !== 1'b1 && n < 2000) begin
        @(posedge i_clk);
        #1 n++;
      end
      chk(8'(n >= 8 * dv && n <= 10 * dv + 4), 8'h01);
      rd(8'h1f, rd_v);
      chk(rd_v & 8'h04, 8'h00);
      rd(8'h1e, rd_v);
      chk(rd_v, LVL[m*8 +: 8]);
      wr(8'h21, 8'h00);
      chk(8'(o_irq), 8'h00);
      wr(8'h21, 8'h01);
      chk(8'(o_irq), 8'h01);
      wr(8'h20, 8'h01);
      chk(8'(o_irq), 8'h00);
    end
    @(posedge i_clk) i_sleep <= 1'b1;
    wr(8'h1f, 8'h05);
    repeat (100) @(posedge i_clk);
    #1 chk(8'(o_irq), 8'h00);
    @(posedge i_clk) i_rst_b <= 1'b0;
    @(posedge i_clk) i_rst_b <= 1'b1;
    #1 chk({5'h00, o_powered, o_sample, o_irq}, 8'h00);
    @(posedge i_clk) i_sleep <= 1'b0;
    repeat (100) @(posedge i_clk);
    rd(8'h1f, rd_v);
    chk(rd_v, 8'h00);
    rd(8'h20, rd_v);
    chk(rd_v, 8'h00);
    finish_test;
  end
  // Longest run is about 750 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    finish_test;
  end
endmodule // tb_sadc_ctrl
